/* hw/bar_setup_pkg.sv */
`default_nettype none
package bar_setup_pkg;

    // register byte addresses
    localparam logic [7:0] down_mem3_upper_size_setup_addr = 8'h18;
    localparam logic [7:0] up_mem3_window_setup_addr       = 8'h34;
    localparam logic [7:0] up_mem3_upper_size_setup_addr   = 8'h38;
    localparam logic [7:0] translation_entry_pointer_addr  = 8'h50;
    localparam logic [7:0] translation_entry_data_addr     = 8'h54;

    // field layout of the upper setup registers
    localparam int upper_enable_bit = 31;
    localparam logic [30:0] upper_size_reset = 31'h0000_0000;

    // field layout of the window setup register
    localparam int win_type_bit     = 0;
    localparam int win_prefetch_bit = 3;
    localparam logic [1:0] win_addr_type_reset = 2'h1;
    localparam logic [19:0] win_size_reset = 20'h00000;

    // lookup table
    localparam int entry_count = 64;
    localparam int entry_index_width = 6;
    localparam logic [7:0] pointer_reset = 8'h00;
    localparam logic [31:0] entry_data_mask = 32'hffff_ff09;

    typedef struct packed {
        logic        enable;
        logic [30:0] size_mask;
    } upper_setup_t;

    typedef struct packed {
        logic [19:0] size_mask;
        logic [7:0]  reserved;
        logic        prefetch;
        logic [1:0]  addr_type;
        logic        space_type;
    } window_setup_t;

endpackage
`default_nettype wire

/* hw/bar_window_setup_regs.sv */
// Notes on behaviour
// - upper setup size bits 30:0 gate writability of upper base bits; reset zero
// - upper setup bit 31 enables the 64-bit base register; reset zero
// - window setup bit 0 is read-only zero, memory space
// - window setup bits 2:1 read-only, read 01 for 64-bit space
// - window setup bits 31:12 gate base register bit writability; reset zero
// - pointer holds byte offset in bits 7:0, resets 00h, upper zero
// - pointer write alone starts no entry access; data access does
// - data write stores bits 31:8, 3 and 0 to selected entry, others zero; data read returns it
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module bar_window_setup_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             down_mem3_upper_enable,
    output logic      [30:0] down_mem3_upper_writable,
    output logic             up_mem3_upper_enable,
    output logic      [30:0] up_mem3_upper_writable,
    output logic      [19:0] up_mem3_base_writable,
    output logic             up_mem3_prefetch,
    output logic             up_mem3_is_64bit,
    output logic      [7:0]  entry_pointer
);

    bar_setup_pkg::upper_setup_t  down_upper_reg;
    bar_setup_pkg::upper_setup_t  up_upper_reg;
    logic                         prefetch_reg;
    logic [19:0]                  win_size_reg;
    logic [7:0]                   pointer_reg;
    logic                         read_wait_reg;
    bar_setup_pkg::window_setup_t win_view;
    logic [31:0]                  table_rdata;
    logic [31:0]                  read_mux;

    // bus decode
    wire setup_phase = psel & ~penable;
    wire access      = psel & penable;
    wire wr_access   = access & pwrite & pready;
    wire hit_down    = paddr == bar_setup_pkg::down_mem3_upper_size_setup_addr;
    wire hit_win     = paddr == bar_setup_pkg::up_mem3_window_setup_addr;
    wire hit_up      = paddr == bar_setup_pkg::up_mem3_upper_size_setup_addr;
    wire hit_ptr     = paddr == bar_setup_pkg::translation_entry_pointer_addr;
    wire hit_data    = paddr == bar_setup_pkg::translation_entry_data_addr;
    wire hit_any     = hit_down | hit_win | hit_up | hit_ptr | hit_data;

    // table access only from a data-register access, never the pointer
    wire table_wr    = wr_access & hit_data;
    wire table_rd    = setup_phase & ~pwrite & hit_data;

    // table read data arrives a cycle late, so reads of it wait once
    assign pready  = ~(access & ~pwrite & hit_data & read_wait_reg);
    assign pslverr = access & ~hit_any;

    // window setup view with fixed type fields
    always_comb begin
        win_view            = '0;
        win_view.space_type = 1'b0;
        win_view.addr_type  = bar_setup_pkg::win_addr_type_reset;
        win_view.prefetch   = prefetch_reg;
        win_view.size_mask  = win_size_reg;
    end

    // read mux; reserved and unmapped read zero
    assign read_mux = hit_down ? down_upper_reg :
                      hit_up   ? up_upper_reg :
                      hit_win  ? win_view :
                      hit_ptr  ? {24'h000000, pointer_reg} :
                      hit_data ? table_rdata :
                                 32'h0000_0000;

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            down_upper_reg <= '0;
            up_upper_reg   <= '0;
            prefetch_reg   <= 1'b0;
            win_size_reg   <= bar_setup_pkg::win_size_reset;
            pointer_reg    <= bar_setup_pkg::pointer_reset;
        end else if (wr_access) begin
            if (hit_down) down_upper_reg <= pwdata;
            if (hit_up) up_upper_reg <= pwdata;
            if (hit_win) begin
                prefetch_reg <= pwdata[bar_setup_pkg::win_prefetch_bit];
                win_size_reg <= pwdata[31:12];
            end
            if (hit_ptr) pointer_reg <= pwdata[7:0];
        end
    end

    // one wait state for table reads; read data taken from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_wait_reg <= 1'b1;
            prdata        <= 32'h0000_0000;
        end else begin
            read_wait_reg <= ~(access & ~pwrite & hit_data & read_wait_reg);
            if (setup_phase & ~pwrite & ~hit_data) prdata <= read_mux;
            if (access & ~pwrite & hit_data & read_wait_reg) prdata <= read_mux;
        end
    end

    // table indexed by the pointer in words
    translation_table u_table (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (table_wr),
        .rd_en   (table_rd),
        .index   (pointer_reg[bar_setup_pkg::entry_index_width+1:2]),
        .wdata   (pwdata),
        .rdata   (table_rdata)
    );

    // size masks steer writability of the base registers downstream
    assign down_mem3_upper_enable   = down_upper_reg.enable;
    assign down_mem3_upper_writable = down_upper_reg.size_mask;
    assign up_mem3_upper_enable     = up_upper_reg.enable;
    assign up_mem3_upper_writable   = up_upper_reg.size_mask;
    assign up_mem3_base_writable    = win_size_reg;
    assign up_mem3_prefetch         = prefetch_reg;
    assign up_mem3_is_64bit         = win_view.addr_type[0];
    assign entry_pointer            = pointer_reg;

endmodule // bar_window_setup_regs

`default_nettype wire

/* hw/translation_table.sv */
`timescale 1ns/100ps
`default_nettype none

// small lookup table store; written and read only on demand
module translation_table (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   wr_en,
    input  wire logic                                   rd_en,
    input  wire logic [bar_setup_pkg::entry_index_width-1:0] index,
    input  wire logic [31:0]                            wdata,
    output logic      [31:0]                            rdata
);

    logic [31:0] entry_mem [bar_setup_pkg::entry_count];

    // entries clear at reset so reads never return unknowns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < bar_setup_pkg::entry_count; i++) begin
                entry_mem[i] <= 32'h0000_0000;
            end
            rdata <= 32'h0000_0000;
        end else begin
            if (wr_en) begin
                entry_mem[index] <= wdata & bar_setup_pkg::entry_data_mask;
            end
            if (rd_en) begin
                rdata <= entry_mem[index];
            end
        end
    end

endmodule // translation_table

`default_nettype wire

/* verification/bar_window_setup_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module bar_window_setup_regs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        up_mem3_is_64bit,
    input wire logic [7:0]  entry_pointer
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pointer writes answer at once, so pready is left out of that decode
    wire logic wr50  = psel && penable && pwrite && paddr == 8'h50;
    wire logic rd_ok = psel && penable && pready && !pwrite;
    wire logic [7:0] wbyte = pwdata[7:0];
    chk_ptr_write: assert property (wr50 |=>
        entry_pointer == $past(wbyte)) else $error("pointer write");
    chk_ptr_hold: assert property (!wr50 |=> $stable(entry_pointer))
        else $error("pointer moved");
    chk_ptr_read: assert property (rd_ok && paddr == 8'h50 |->
        prdata == {24'h0, entry_pointer}) else $error("pointer read");
    chk_fixed_bits: assert property (rd_ok && paddr == 8'h34 |->
        prdata[2:0] == 3'h2) else $error("window fixed bits");
    chk_addr_type: assert property (up_mem3_is_64bit) else $error("type");
    chk_data_wait: assert property (psel && !penable && !pwrite &&
        paddr == 8'h54 |=> !pready ##1 pready) else $error("data wait");
    chk_zero_wait: assert property (psel && !penable && (pwrite ||
        paddr != 8'h54) |=> pready) else $error("late answer");
    chk_bad_addr: assert property (psel && penable |-> pslverr == !(paddr
        inside {8'h18, 8'h34, 8'h38, 8'h50, 8'h54})) else $error("error");
    cover property (wr50);
    cover property (rd_ok && paddr == 8'h54);
    cover property (psel && penable && pslverr);
endmodule // bar_window_setup_regs_chk
bind bar_window_setup_regs bar_window_setup_regs_chk chk_i (.*);
`default_nettype wire

/* verification/test_bar_window_setup_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_bar_window_setup_regs;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, up_mem3_is_64bit, up_mem3_prefetch;
    logic down_mem3_upper_enable, up_mem3_upper_enable;
    logic [7:0] paddr = 8'h00, entry_pointer;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [30:0] down_mem3_upper_writable, up_mem3_upper_writable;
    logic [19:0] up_mem3_base_writable;
    int num_errors = 0, compares = 0;
    always #2 pclk = ~pclk; // 250 MHz register clock
    bar_window_setup_regs bar_window_setup_regs_i (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .down_mem3_upper_enable   (down_mem3_upper_enable),
        .down_mem3_upper_writable (down_mem3_upper_writable),
        .up_mem3_upper_enable     (up_mem3_upper_enable),
        .up_mem3_upper_writable   (up_mem3_upper_writable),
        .up_mem3_base_writable    (up_mem3_base_writable),
        .up_mem3_prefetch         (up_mem3_prefetch),
        .up_mem3_is_64bit         (up_mem3_is_64bit),
        .entry_pointer            (entry_pointer)
    );
    // one compare; !== so an unknown counts as a mismatch
    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer held until pready is seen high at a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              input logic [31:0] e = 32'h0, input logic ee = 1'b0);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        check({31'h0, pslverr}, {31'h0, ee});
        if (!w) check(prdata, e);
        {psel, penable} <= 2'h0;
    endtask
    // pins sampled an edge after the last write, once they have settled
    task test_pins(input logic [31:0] d, input logic [31:0] u,
                   input logic [31:0] w, input logic [31:0] p);
        @(posedge pclk);
        check({down_mem3_upper_enable, down_mem3_upper_writable}, d);
        check({up_mem3_upper_enable, up_mem3_upper_writable}, u);
        check({up_mem3_base_writable, 8'h00, up_mem3_prefetch,
               1'b0, up_mem3_is_64bit, 1'b0}, w);
        check({24'h0, entry_pointer}, p);
    endtask
    task test_fields;
        test_pins(32'h0, 32'h0, 32'h0000_0002, 32'h0);
        xfer(1'b0, 8'h18, 32'h0, 32'h0000_0000);
        xfer(1'b0, 8'h38, 32'h0, 32'h0000_0000);
        xfer(1'b0, 8'h34, 32'h0, 32'h0000_0002);
        xfer(1'b1, 8'h18, 32'hffff_ffff);
        xfer(1'b1, 8'h38, 32'h8000_1234);
        xfer(1'b1, 8'h34, 32'hffff_ffff);
        xfer(1'b0, 8'h18, 32'h0, 32'hffff_ffff);
        xfer(1'b0, 8'h38, 32'h0, 32'h8000_1234);
        xfer(1'b0, 8'h34, 32'h0, 32'hffff_f00a);
        test_pins(32'hffff_ffff, 32'h8000_1234, 32'hffff_f00a, 32'h0);
        xfer(1'b1, 8'h34, 32'h0000_0008);
        xfer(1'b0, 8'h34, 32'h0, 32'h0000_000a);
        xfer(1'b0, 8'h1c, 32'h0, 32'h0000_0000, 1'b1);
        xfer(1'b1, 8'h1c, 32'hffff_ffff, 32'h0, 1'b1);
        $display("test_fields done");
    endtask
    task test_table;
        xfer(1'b1, 8'h50, 32'hffff_ff04);
        xfer(1'b0, 8'h50, 32'h0, 32'h0000_0004);
        test_pins(32'hffff_ffff, 32'h8000_1234, 32'h0000_000a, 32'h4);
        xfer(1'b1, 8'h54, 32'hffff_ffff);
        xfer(1'b0, 8'h54, 32'h0, 32'hffff_ff09);
        xfer(1'b1, 8'h50, 32'h0000_0008);
        xfer(1'b0, 8'h54, 32'h0, 32'h0000_0000);
        $display("test_table done");
    endtask
    task summarize;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_fields();
        test_table();
        summarize();
    end
    initial begin
        repeat (1000) @(posedge pclk);
        num_errors++;
        summarize();
    end
endmodule // test_bar_window_setup_regs
`default_nettype wire
